// *** verilog/crs_pkg.sv ***
// Constants for the clock and reset wake-up sequencer
package crs_pkg;
    // ****************************************
    // Reset sequence timing
    // ****************************************
    localparam int CRS_CLK_MHZ = 100;
    localparam int CRS_PIN_LOW_CYCLES = 128;
    localparam int CRS_SAMPLE_WAIT_CYCLES = 64;
    localparam int CRS_SEQ_CYCLES = CRS_PIN_LOW_CYCLES + CRS_SAMPLE_WAIT_CYCLES;
    localparam int CRS_SYNC_EXTRA = 3;
    localparam int CRS_CHECK_WINDOWS = 50;
    localparam logic [7:0] CRS_CNT_W0 = 8'h00;
    // ****************************************
    // Watchdog constants
    // ****************************************
    localparam logic [15:0] CRS_ARM_FIRST = 16'h0055;
    localparam logic [15:0] CRS_ARM_SECOND = 16'h00aa;
    localparam logic [2:0] CRS_RATE_OFF = 3'h0;
    // ****************************************
    // Reset vector encoding
    // ****************************************
    localparam logic [1:0] CRS_VEC_NORMAL = 2'h0;
    localparam logic [1:0] CRS_VEC_MONITOR = 2'h1;
    localparam logic [1:0] CRS_VEC_WATCHDOG = 2'h2;
    // ****************************************
    // Sequencer states
    // ****************************************
    typedef enum logic [5:0] {
        CRS_RUN = 6'h01,
        CRS_CHECK = 6'h02,
        CRS_PIN_LOW = 6'h04,
        CRS_WAIT = 6'h08,
        CRS_HOLD = 6'h10,
        CRS_STOP = 6'h20
    } crs_state_t;
endpackage : crs_pkg

// *** verilog/crs_flag.sv ***
// Sticky event flag with write-one-to-clear and local enable
`timescale 1ns/100ps
module crs_flag
    import crs_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Event and software access
    input wire logic set_i,
    input wire logic clear_i,
    input wire logic irq_en_i,
    // Flag and request
    output logic flag_o,
    output logic irq_o
);
    logic flag;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            flag <= 1'b0;
        else if (set_i)
            flag <= 1'b1;
        else if (clear_i)
            flag <= 1'b0;
    end

    assign flag_o = flag;
    assign irq_o = flag & irq_en_i;
endmodule : crs_flag

// *** verilog/crs_sequencer.sv ***
// Clock and reset wake-up sequencer top
//
// Functional notes
// RL1: Pseudo-stop clock loss enters self-clock, wakes core
// RL2: Full stop exits only on external interrupt/reset
// RL3: External reset in full stop: defaults, checks, sequence
// RL4: Interrupt wake: checks, then release or fail
// RL5: Leaving full stop clears PLL source select
// RL6: Clock monitor ignored during full stop
// RL7: Reset on pin, power, voltage, watchdog, monitor
// RL8: Drive reset pin low 128 plus sync cycles
// RL9: Asynchronous entry, sequencing needs running clock
// RL10: Wait 64 cycles then sample reset pin
// RL11: Vector from sampled pin and pending causes
// RL12: Internal reset held 192 cycles or pin low
// RL13: Monitor reset forces enables, self-clock, check
// RL14: Watchdog needs 0x55 then 0xaa each period
// RL15: Windowed mode: writes only in final quarter
// RL16: Power reset checks clock before sequence start
// RL17: Periodic flag sets on timeout, write-one clears
// RL18: Periodic counter runs in pseudo-stop if kept
// RL19: Lock flag sets on any lock change
// RL20: Self-clock flag sets on entry or exit
// RL21: Encoded reset vector output held until reset
`timescale 1ns/100ps
module crs_sequencer
    import crs_pkg::*;
#(
    parameter int WDOG_W = 16,
    parameter int RTI_W = 16
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Reset sources
    input wire logic power_on_i,
    input wire logic low_voltage_reset_i,
    input wire logic clk_fail_i,
    // Reset pin, open drain
    input wire logic reset_pin_i,
    output logic reset_pin_o,
    output logic reset_pin_oe_o,
    // Stop mode and wake-up
    input wire logic stop_req_i,
    input wire logic pseudo_stop_select_i,
    input wire logic ext_irq_i,
    input wire logic osc_good_i,
    input wire logic check_window_i,
    input wire logic osc_keep_running_i,
    // Control bits
    input wire logic clk_monitor_en_set_i,
    input wire logic clk_monitor_en_clr_i,
    input wire logic self_clk_en_clr_i,
    input wire logic pll_source_select_set_i,
    input wire logic [2:0] watchdog_rate_field_i,
    input wire logic watchdog_window_i,
    input wire logic [WDOG_W-1:0] watchdog_period_i,
    input wire logic arm_wr_i,
    input wire logic [15:0] arm_data_i,
    // Interrupt flags and enables
    input wire logic [RTI_W-1:0] periodic_period_i,
    input wire logic periodic_irq_en_i,
    input wire logic periodic_flag_clr_i,
    input wire logic pll_lock_i,
    input wire logic pll_lock_irq_en_i,
    input wire logic pll_lock_flag_clr_i,
    input wire logic self_clk_irq_en_i,
    input wire logic self_clk_flag_clr_i,
    // Status and outputs
    output logic clk_monitor_en_o,
    output logic self_clk_en_o,
    output logic self_clocked_state_o,
    output logic pll_source_select_o,
    output logic regulator_en_o,
    output logic pll_en_o,
    output logic clocks_released_o,
    output logic core_wake_o,
    output logic internal_reset_o,
    output logic [1:0] reset_vector_o,
    output logic periodic_flag_o,
    output logic pll_lock_flag_o,
    output logic self_clk_flag_o,
    output logic irq_o
);
    // ****************************************
    // Reset release synchroniser
    // ****************************************
    logic rst_s1;
    logic rst_s2;
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end
        else
        begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end

    // ****************************************
    // Decode
    // ****************************************
    crs_state_t state;
    crs_state_t next_state;
    logic [7:0] cnt;
    logic [5:0] win_cnt;
    logic cm_pend;
    logic wd_pend;
    logic self_clocked;
    logic clk_monitor_en;
    logic self_clk_en;
    logic pll_sel;
    logic stop_irq_wake;
    logic [WDOG_W-1:0] wd_cnt;
    logic arm_half;
    logic [RTI_W-1:0] rti_cnt;
    logic lock_d;
    logic scm_d;

    wire in_stop = (state == CRS_STOP);
    wire pseudo = in_stop & pseudo_stop_select_i;
    wire full_stop = in_stop & ~pseudo_stop_select_i;
    wire mon_fail = clk_fail_i & clk_monitor_en & ~full_stop;                      // [RL6]
    wire cm_reset = mon_fail & ~self_clk_en;                                   // [RL7]
    wire scm_enter = mon_fail & self_clk_en;
    wire wd_on = (watchdog_rate_field_i != CRS_RATE_OFF);               // [RL7]
    wire wd_timeout = wd_on & (wd_cnt >= watchdog_period_i);
    wire in_last_quarter = wd_cnt >= (watchdog_period_i - (watchdog_period_i >> 2));
    wire arm_bad = arm_wr_i & wd_on & (((arm_data_i != CRS_ARM_FIRST)
                   & (arm_data_i != CRS_ARM_SECOND))
                   | (arm_half & (arm_data_i != CRS_ARM_SECOND)));       // [RL14]
    wire arm_early = arm_wr_i & wd_on & watchdog_window_i & ~in_last_quarter; // [RL15]
    wire arm_done = arm_wr_i & arm_half & (arm_data_i == CRS_ARM_SECOND);
    wire wd_reset = wd_timeout | arm_bad | arm_early;
    wire pin_ext = ~reset_pin_i & (state == CRS_RUN | in_stop);
    wire any_reset = cm_reset | wd_reset | pin_ext;                     // [RL7]
    wire windows_out = (win_cnt == 6'(CRS_CHECK_WINDOWS));
    wire full_wake = full_stop & (ext_irq_i | ~reset_pin_i);            // [RL2]
    wire rti_tick = (rti_cnt == periodic_period_i) & (~in_stop | (pseudo & osc_keep_running_i));
    wire lock_chg = lock_d ^ pll_lock_i;
    wire scm_chg = scm_d ^ self_clocked;
    wire pin_done = (cnt == 8'(CRS_PIN_LOW_CYCLES + CRS_SYNC_EXTRA - 1)); // [RL8]
    wire wait_done = (cnt == 8'(CRS_SAMPLE_WAIT_CYCLES - 1));            // [RL10]
    wire pwr_event = power_on_i | low_voltage_reset_i;                  // [RL7] [RL16]

    // ****************************************
    // Sequencer next state
    // ****************************************
    always_comb
    begin
        next_state = state;
        case (state)
            CRS_RUN:
                if (any_reset)
                    next_state = CRS_PIN_LOW;
                else if (stop_req_i)
                    next_state = CRS_STOP;
            CRS_CHECK:                                                  // [RL16]
                if (osc_good_i | windows_out)
                    next_state = stop_irq_wake ? CRS_RUN : CRS_PIN_LOW;
            CRS_PIN_LOW:
                if (pin_done)
                    next_state = CRS_WAIT;
            CRS_WAIT:
                if (wait_done)
                    next_state = CRS_HOLD;
            CRS_HOLD:                                                   // [RL12]
                if (reset_pin_i)
                    next_state = CRS_RUN;
            CRS_STOP:
                if (full_wake)
                    next_state = CRS_CHECK;                             // [RL3] [RL4]
                else if (pseudo & ~reset_pin_i)
                    next_state = CRS_PIN_LOW;
                else if (pseudo & (ext_irq_i | rti_tick & periodic_irq_en_i
                         | scm_enter & self_clk_irq_en_i))              // [RL1] [RL18]
                    next_state = CRS_RUN;
                else if (cm_reset)
                    next_state = CRS_PIN_LOW;
            default:
                next_state = CRS_RUN;
        endcase
        if (pwr_event)
            next_state = CRS_CHECK;                                     // [RL16]
    end

    // ****************************************
    // Sequencer registers
    // ****************************************
    always_ff @(posedge clk_i or negedge rst_s2)                        // [RL9]
    begin
        if (!rst_s2)
        begin
            state <= CRS_CHECK;                                         // [RL16]
            cnt <= CRS_CNT_W0;
            win_cnt <= 6'h00;
            stop_irq_wake <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cnt <= (next_state != state) ? CRS_CNT_W0 : cnt + 8'h01;
            if (state != CRS_CHECK)
                win_cnt <= 6'h00;
            else if (check_window_i & ~windows_out)
                win_cnt <= win_cnt + 6'h01;
            if (pwr_event)
                stop_irq_wake <= 1'b0;
            else if (full_wake)
                stop_irq_wake <= reset_pin_i;
            else if (state == CRS_CHECK && next_state != CRS_CHECK)
                stop_irq_wake <= 1'b0;
        end
    end

    // ****************************************
    // Configuration bits and self-clock mode
    // ****************************************
    wire stop_ext_rst = full_stop & ~reset_pin_i;
    wire check_fail = (state == CRS_CHECK) & windows_out & ~osc_good_i;
    wire wake_cm_reset = check_fail & stop_irq_wake & ~self_clk_en;            // [RL4]
    always_ff @(posedge clk_i or negedge rst_s2)
    begin
        if (!rst_s2)
        begin
            clk_monitor_en <= 1'b1;
            self_clk_en <= 1'b1;
            pll_sel <= 1'b0;
            self_clocked <= 1'b0;
            cm_pend <= 1'b0;
            wd_pend <= 1'b0;
            reset_vector_o <= CRS_VEC_NORMAL;
        end
        else
        begin
            if (stop_ext_rst | cm_reset | wake_cm_reset)                // [RL3] [RL13]
            begin
                clk_monitor_en <= 1'b1;
                self_clk_en <= 1'b1;
            end
            else
            begin
                if (clk_monitor_en_set_i)
                    clk_monitor_en <= 1'b1;
                else if (clk_monitor_en_clr_i)
                    clk_monitor_en <= 1'b0;
                if (self_clk_en_clr_i)
                    self_clk_en <= 1'b0;
            end
            if (full_wake | stop_ext_rst)
                pll_sel <= 1'b0;                                        // [RL5]
            else if (pll_source_select_set_i)
                pll_sel <= 1'b1;
            if (scm_enter | cm_reset | wake_cm_reset)                   // [RL1] [RL13]
                self_clocked <= 1'b1;
            else if (check_fail & self_clk_en)
                self_clocked <= 1'b1;                                   // [RL4] [RL16]
            else if (osc_good_i)
                self_clocked <= 1'b0;
            if (cm_reset | wake_cm_reset)
                cm_pend <= 1'b1;
            else if (state == CRS_HOLD && reset_pin_i)
                cm_pend <= 1'b0;
            if (wd_reset & state == CRS_RUN)
                wd_pend <= 1'b1;
            else if (state == CRS_HOLD && reset_pin_i)
                wd_pend <= 1'b0;
            if (state == CRS_WAIT && wait_done)                         // [RL11] [RL21]
                reset_vector_o <= ~reset_pin_i ? CRS_VEC_NORMAL
                    : cm_pend ? CRS_VEC_MONITOR
                    : wd_pend ? CRS_VEC_WATCHDOG : CRS_VEC_NORMAL;
        end
    end

    // ****************************************
    // Watchdog
    // ****************************************
    always_ff @(posedge clk_i or negedge rst_s2)
    begin
        if (!rst_s2)
        begin
            wd_cnt <= '0;
            arm_half <= 1'b0;
        end
        else if (state != CRS_RUN || !wd_on || arm_done)                 // [RL14]
        begin
            wd_cnt <= '0;
            arm_half <= 1'b0;
        end
        else
        begin
            wd_cnt <= wd_cnt + 1'b1;
            if (arm_wr_i && arm_data_i == CRS_ARM_FIRST)
                arm_half <= 1'b1;
        end
    end

    // ****************************************
    // Periodic counter and change detectors
    // ****************************************
    always_ff @(posedge clk_i or negedge rst_s2)
    begin
        if (!rst_s2)
        begin
            rti_cnt <= '0;
            lock_d <= 1'b0;
            scm_d <= 1'b0;
        end
        else
        begin
            if (rti_tick)
                rti_cnt <= '0;
            else if (~in_stop | (pseudo & osc_keep_running_i))          // [RL18]
                rti_cnt <= rti_cnt + 1'b1;
            lock_d <= pll_lock_i;
            scm_d <= self_clocked;
        end
    end

    // ****************************************
    // Interrupt flags
    // ****************************************
    logic rti_irq;
    logic lock_irq;
    logic scm_irq;
    crs_flag u_rti_flag (
        .clk_i(clk_i), .rst_n_i(rst_s2), .set_i(rti_tick),              // [RL17]
        .clear_i(periodic_flag_clr_i), .irq_en_i(periodic_irq_en_i),
        .flag_o(periodic_flag_o), .irq_o(rti_irq));
    crs_flag u_lock_flag (
        .clk_i(clk_i), .rst_n_i(rst_s2), .set_i(lock_chg),              // [RL19]
        .clear_i(pll_lock_flag_clr_i), .irq_en_i(pll_lock_irq_en_i),
        .flag_o(pll_lock_flag_o), .irq_o(lock_irq));
    crs_flag u_scm_flag (
        .clk_i(clk_i), .rst_n_i(rst_s2), .set_i(scm_chg | scm_enter),   // [RL20] [RL1]
        .clear_i(self_clk_flag_clr_i), .irq_en_i(self_clk_irq_en_i),
        .flag_o(self_clk_flag_o), .irq_o(scm_irq));

    // ****************************************
    // Outputs
    // ****************************************
    assign irq_o = rti_irq | lock_irq | scm_irq;
    assign reset_pin_o = 1'b0;
    assign reset_pin_oe_o = ~rst_s2 | (state == CRS_PIN_LOW)
        | (state == CRS_CHECK & ~stop_irq_wake);                        // [RL8] [RL16]
    assign internal_reset_o = ~rst_s2 | (state == CRS_CHECK & ~stop_irq_wake)
        | (state == CRS_PIN_LOW) | (state == CRS_WAIT) | (state == CRS_HOLD); // [RL12]
    assign clk_monitor_en_o = clk_monitor_en;
    assign self_clk_en_o = self_clk_en;
    assign self_clocked_state_o = self_clocked;
    assign pll_source_select_o = pll_sel;
    assign regulator_en_o = ~full_stop & ~(pseudo & ~self_clocked);     // [RL1]
    assign pll_en_o = ~full_stop & (pll_sel | self_clocked);
    assign clocks_released_o = ~in_stop & (state != CRS_CHECK);         // [RL4]
    assign core_wake_o = in_stop & (next_state == CRS_RUN);
endmodule : crs_sequencer

// *** verification/crs_seq_assertions.sv ***
// Concurrent checks on the sequencer ports
`timescale 1ns/100ps
module crs_seq_assertions
    import crs_pkg::*;
(
    // Clock, reset and pin
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic reset_pin_o,
    input wire logic reset_pin_oe_o,
    input wire logic internal_reset_o,
    // Watchdog and vector
    input wire logic arm_wr_i,
    input wire logic [15:0] arm_data_i,
    input wire logic [2:0] watchdog_rate_field_i,
    input wire logic [1:0] reset_vector_o,
    // Flags and request
    input wire logic pll_lock_i,
    input wire logic pll_lock_flag_o,
    input wire logic periodic_flag_o,
    input wire logic periodic_irq_en_i,
    input wire logic pll_lock_irq_en_i,
    input wire logic self_clk_flag_o,
    input wire logic self_clk_irq_en_i,
    input wire logic irq_o
);
    // ****************************************
    // Pin drive length and properties
    // ****************************************
    logic [8:0] oe_cnt;
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            oe_cnt <= 9'h000;
        else if (!reset_pin_oe_o)
            oe_cnt <= 9'h000;
        else if (oe_cnt != 9'h1ff)
            oe_cnt <= oe_cnt + 9'h001;
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence s_release;
        $fell(reset_pin_oe_o);
    endsequence
    sequence s_wait_held;
        internal_reset_o throughout (##63 1'b1);
    endsequence
    chk_pin_low_len: assert property (s_release |-> oe_cnt >= 9'h080)
        else $error("reset pin released too early");
    chk_wait_held: assert property (s_release |-> s_wait_held)
        else $error("internal reset dropped before sample");
    chk_oe_in_reset: assert property (reset_pin_oe_o |-> internal_reset_o)
        else $error("pin driven outside internal reset");
    chk_pin_drive_low: assert property (reset_pin_oe_o |-> !reset_pin_o)
        else $error("reset pin driven high");
    chk_arm_bad_value: assert property (!internal_reset_o && arm_wr_i
        && watchdog_rate_field_i != CRS_RATE_OFF && arm_data_i != CRS_ARM_FIRST
        && arm_data_i != CRS_ARM_SECOND |-> ##[1:4] reset_pin_oe_o)
        else $error("bad arm value did not reset");
    chk_vector_hold: assert property (!internal_reset_o && !$past(internal_reset_o)
        |-> $stable(reset_vector_o))
        else $error("vector changed outside reset");
    chk_lock_flag_set: assert property (!internal_reset_o && $changed(pll_lock_i)
        |-> ##[1:3] pll_lock_flag_o)
        else $error("lock change not flagged");
    chk_irq_gated: assert property (irq_o |-> (periodic_flag_o && periodic_irq_en_i)
        || (pll_lock_flag_o && pll_lock_irq_en_i) || (self_clk_flag_o && self_clk_irq_en_i))
        else $error("request without enabled flag");
endmodule : crs_seq_assertions
bind crs_sequencer crs_seq_assertions u_chk (.clk_i, .rst_n_i, .reset_pin_o, .reset_pin_oe_o,
    .internal_reset_o, .arm_wr_i, .arm_data_i, .watchdog_rate_field_i, .reset_vector_o,
    .pll_lock_i, .pll_lock_flag_o, .periodic_flag_o, .periodic_irq_en_i, .pll_lock_irq_en_i,
    .self_clk_flag_o, .self_clk_irq_en_i, .irq_o);

// *** verification/crs_pin_model.sv ***
// External reset circuitry with pull-up on the reset pin
`timescale 1ns/100ps
module crs_pin_model
(
    // Clock and design pin side
    input wire logic clk_i,
    input wire logic reset_pin_o,
    input wire logic reset_pin_oe_o,
    // Bench controls
    input wire logic hold_low_i,
    input wire logic [3:0] rise_delay_i,
    // Resolved pin level
    output logic pin_level_o
);
    logic [3:0] rise_cnt;
    wire logic drive_low = reset_pin_oe_o && !reset_pin_o;
    always_ff @(posedge clk_i)
    begin
        if (drive_low || hold_low_i)
            rise_cnt <= rise_delay_i;
        else if (rise_cnt != 4'h0)
            rise_cnt <= rise_cnt - 4'h1;
    end
    // Slow pull-up still rises well inside the sample wait
    assign pin_level_o = !(drive_low || hold_low_i || rise_cnt != 4'h0);
endmodule : crs_pin_model

// *** verification/crs_sequencer_tb.sv ***
// Self-checking bench for the sequencer
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module crs_sequencer_tb
    import crs_pkg::*;
;
    // ****************************************
    // Signals, helpers and sequence
    // ****************************************
    logic clk_i = 1'b0, rst_n_i = 1'b0, power_on_i = 1'b0, low_voltage_reset_i = 1'b0;
    logic clk_fail_i = 1'b0, stop_req_i = 1'b0, pseudo_stop_select_i = 1'b0, ext_irq_i = 1'b0;
    logic osc_good_i = 1'b1, check_window_i = 1'b0, osc_keep_running_i = 1'b0;
    logic clk_monitor_en_set_i = 1'b0, clk_monitor_en_clr_i = 1'b0, self_clk_en_clr_i = 1'b0;
    logic pll_source_select_set_i = 1'b0, watchdog_window_i = 1'b0, arm_wr_i = 1'b0;
    logic [2:0] watchdog_rate_field_i = 3'h0;
    logic [15:0] watchdog_period_i = 16'h0190, arm_data_i = 16'h0000;
    logic [15:0] periodic_period_i = 16'h00c7;
    logic periodic_irq_en_i = 1'b0, periodic_flag_clr_i = 1'b0, pll_lock_i = 1'b0;
    logic pll_lock_irq_en_i = 1'b0, pll_lock_flag_clr_i = 1'b0;
    logic self_clk_irq_en_i = 1'b0, self_clk_flag_clr_i = 1'b0, hold_low = 1'b0;
    logic [3:0] rise_delay = 4'h0;
    wire logic reset_pin_i, reset_pin_o, reset_pin_oe_o, clk_monitor_en_o, self_clk_en_o;
    wire logic self_clocked_state_o, pll_source_select_o, regulator_en_o, pll_en_o;
    wire logic clocks_released_o, core_wake_o, internal_reset_o, periodic_flag_o;
    wire logic pll_lock_flag_o, self_clk_flag_o, irq_o;
    wire logic [1:0] reset_vector_o;
    int n_fail = 0, cmp_count = 0, k, oe_run = 0, last_run = 0;
    logic [31:0] seed = 32'h5574;
    crs_sequencer dut (.*);
    crs_pin_model u_pin (.clk_i(clk_i), .reset_pin_o(reset_pin_o),
        .reset_pin_oe_o(reset_pin_oe_o), .hold_low_i(hold_low), .rise_delay_i(rise_delay),
        .pin_level_o(reset_pin_i));
    always @(posedge clk_i)
    begin
        if (reset_pin_oe_o === 1'b1)
            oe_run <= oe_run + 1;
        else
        begin
            if (oe_run != 0)
                last_run <= oe_run;
            oe_run <= 0;
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    function automatic logic [1:0] exp_vec(input logic pin, input logic cm, input logic wd);
        return !pin ? CRS_VEC_NORMAL : cm ? CRS_VEC_MONITOR : wd ? CRS_VEC_WATCHDOG : CRS_VEC_NORMAL;
    endfunction : exp_vec
    task automatic tally_and_finish;
        $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc
    task automatic wait_sig(input bit int_rst, input logic lvl);
        for (int i = 0; i < 3000; i++)
        begin
            @(posedge clk_i);
            #1;
            if ((int_rst ? internal_reset_o : reset_pin_oe_o) === lvl)
                return;
        end
        n_fail++;
        $display("Error t=%0t wait ran out for level %h", $time, lvl);
        tally_and_finish();
    endtask : wait_sig
    task automatic seq_check(input logic [1:0] vec);
        wait_sig(1'b0, 1'b1);
        wait_sig(1'b1, 1'b0);
        `CHK(last_run, CRS_PIN_LOW_CYCLES + CRS_SYNC_EXTRA)
        `CHK(reset_vector_o, vec)
    endtask : seq_check
    task automatic arm(input logic [15:0] d);
        @(posedge clk_i);
        arm_wr_i <= 1'b1;
        arm_data_i <= d;
        @(posedge clk_i);
        arm_wr_i <= 1'b0;
    endtask : arm
    task automatic pulse_clears;
        @(posedge clk_i);
        {pll_lock_flag_clr_i, periodic_flag_clr_i, self_clk_flag_clr_i} <= 3'h7;
        @(posedge clk_i);
        {pll_lock_flag_clr_i, periodic_flag_clr_i, self_clk_flag_clr_i} <= 3'h0;
        #1;
    endtask : pulse_clears
    initial
    begin
        forever #5 clk_i = ~clk_i;
    end
    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        wait_sig(1'b1, 1'b0);
        `CHK(reset_vector_o, exp_vec(1'b1, 1'b0, 1'b0))
        for (k = 0; k < 3; k++)
        begin
            seed = xs(seed);
            @(posedge clk_i);
            hold_low <= 1'b1;
            rise_delay <= seed[3:0];
            cyc(2 + seed[7:4]);
            hold_low <= 1'b0;
            seq_check(exp_vec(1'b1, 1'b0, 1'b0));
        end
        @(posedge clk_i);
        hold_low <= 1'b1;
        wait_sig(1'b0, 1'b1);
        cyc(300);
        #1;
        `CHK(internal_reset_o, 1'b1)
        hold_low <= 1'b0;
        wait_sig(1'b1, 1'b0);
        `CHK(reset_vector_o, exp_vec(1'b0, 1'b0, 1'b0))
        low_voltage_reset_i <= 1'b1;
        cyc(1);
        low_voltage_reset_i <= 1'b0;
        cyc(1);
        #1;
        `CHK({internal_reset_o, reset_pin_oe_o}, 2'h3)
        wait_sig(1'b1, 1'b0);
        `CHK(reset_vector_o, exp_vec(1'b1, 1'b0, 1'b0))
        @(posedge clk_i);
        watchdog_rate_field_i <= 3'h1;
        for (k = 0; k < 4; k++)
        begin
            arm(CRS_ARM_FIRST);
            arm(CRS_ARM_SECOND);
            cyc(250);
        end
        watchdog_window_i <= 1'b1;
        cyc(70);
        arm(CRS_ARM_FIRST);
        arm(CRS_ARM_SECOND);
        #1;
        `CHK(internal_reset_o, 1'b0)
        arm(CRS_ARM_FIRST);
        seq_check(exp_vec(1'b1, 1'b0, 1'b1));
        watchdog_window_i <= 1'b0;
        watchdog_rate_field_i <= 3'h0;
        for (k = 0; k < 3; k++)
        begin
            seed = xs(seed);
            @(posedge clk_i);
            watchdog_rate_field_i <= 3'h1 + seed[1:0];
            if (k == 0)
                arm(seed[15:0] | 16'h0100);
            else if (k == 1)
                arm(CRS_ARM_SECOND);
            seq_check(exp_vec(1'b1, 1'b0, 1'b1));
            watchdog_rate_field_i <= 3'h0;
        end
        @(posedge clk_i);
        {pll_source_select_set_i, self_clk_en_clr_i} <= 2'h3;
        @(posedge clk_i);
        {pll_source_select_set_i, self_clk_en_clr_i} <= 2'h0;
        stop_req_i <= 1'b1;
        cyc(4);
        clk_fail_i <= 1'b1;
        cyc(20);
        #1;
        `CHK(reset_pin_oe_o, 1'b0)
        {clk_fail_i, stop_req_i, ext_irq_i} <= 3'h1;
        cyc(30);
        #1;
        ext_irq_i <= 1'b0;
        `CHK(pll_source_select_o, 1'b0)
        `CHK(clocks_released_o, 1'b1)
        @(posedge clk_i);
        clk_monitor_en_clr_i <= 1'b1;
        @(posedge clk_i);
        {clk_monitor_en_clr_i, clk_fail_i} <= 2'h1;
        cyc(10);
        #1;
        `CHK(reset_pin_oe_o, 1'b0)
        {clk_fail_i, clk_monitor_en_set_i} <= 2'h1;
        @(posedge clk_i);
        {clk_monitor_en_set_i, clk_fail_i} <= 2'h1;
        cyc(3);
        clk_fail_i <= 1'b0;
        seq_check(exp_vec(1'b1, 1'b1, 1'b0));
        `CHK({clk_monitor_en_o, self_clk_en_o}, 2'h3)
        pulse_clears();
        {pll_lock_irq_en_i, periodic_irq_en_i, self_clk_irq_en_i, pll_lock_i} <= 4'hf;
        cyc(4);
        #1;
        `CHK({pll_lock_flag_o, irq_o}, 2'h3)
        for (k = 0; k < 400 && periodic_flag_o !== 1'b1; k++)
        begin
            @(posedge clk_i);
            #1;
        end
        `CHK(periodic_flag_o, 1'b1)
        {pll_lock_irq_en_i, periodic_irq_en_i, self_clk_irq_en_i} <= 3'h0;
        #1;
        `CHK(irq_o, 1'b0)
        pulse_clears();
        `CHK({pll_lock_flag_o, periodic_flag_o, self_clk_flag_o}, 3'h0)
        pseudo_stop_select_i <= 1'b1;
        {stop_req_i, self_clk_irq_en_i, osc_good_i} <= 3'h6;
        cyc(3);
        clk_fail_i <= 1'b1;
        #1;
        `CHK({core_wake_o, regulator_en_o, self_clocked_state_o}, 3'h4)
        stop_req_i <= 1'b0;
        cyc(1);
        #1;
        `CHK({self_clocked_state_o, regulator_en_o, pll_en_o, self_clk_flag_o}, 4'hf)
        tally_and_finish();
    end
endmodule : crs_sequencer_tb
